/* File: wr_path_pkg.sv */
/*
 * constants, mode encodings and carrier types for the burst write path.
 * assumes the importer runs a core clock of 10 MHz and a link clock from the memory clock pin.
 */
package wr_path_pkg;
	// command step encodings on ca[4:0] while cs is high
	localparam logic [4:0] WR1_CODE = 5'h04;
	localparam logic [4:0] CAS2_CODE = 5'h12;
	// field positions on ca during the four command edges
	localparam int CA_BL_BIT = 5;
	localparam int CA_C9_BIT = 4;
	localparam int CA_C8_BIT = 5;
	// write latency per set, in link clock periods
	localparam logic [4:0] WL_SET_A = 5'h06;
	localparam logic [4:0] WL_SET_B = 5'h08;
	// last beat index for each burst length
	localparam logic [4:0] LAST_BL16 = 5'h0F;
	localparam logic [4:0] LAST_BL32 = 5'h1F;
	// postamble of 0.5 and 1.5 periods, rounded up to whole periods
	localparam logic [4:0] POST_STD_CYC = 5'h01;
	localparam logic [4:0] POST_EXT_CYC = 5'h02;
	// preamble length the controller provides, in link periods
	localparam int PRE_CYC = 2;
	// write recovery, counted on the core clock
	localparam int CLK_NS = 100;
	localparam int TWR_NS = 18;
	localparam int TWR_RAW = (TWR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] TWR_CYC = (TWR_RAW < 1) ? 4'h1 : 4'(TWR_RAW);

	// one completed burst as handed to the core
	typedef struct packed {
		logic [2:0] bank;
		logic [9:0] col;
		logic bl32;
		logic align_err;
	} burst_s;

	// link side sequencer, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_W1B = 7'h02,
		ST_C2A = 7'h04,
		ST_C2B = 7'h08,
		ST_LAT = 7'h10,
		ST_BURST = 7'h20,
		ST_POST = 7'h40
	} link_st_e;
endpackage : wr_path_pkg

/* File: burst_write_strobe_path.sv */
/*
 * burst write path of one memory channel: command decode, write latency,
 * strobe-qualified beat capture, postamble wait and write recovery tracking.
 * assumes ck is the memory clock, cs/ca/dqs_t/dq arrive aligned to it,
 * and the mode bits come from the core clock domain.
 */
// Behaviour
// - strobe has preamble before first latching edge and postamble after the last
// - preamble and postamble lengths come from mode settings the device applies; here only postamble has one (wpst_ext), preamble is fixed at PRE_CYC
// - extended postamble setting adds one period, one and a half in total
// - device ignores strobe state and transitions before the preamble window
// - column bits 3:0 are zero so bursts start on 32 byte boundaries
// - write latency counts from the second edge of the second column step
// - device captures beats on successive strobe edges until 16 or 32 arrive
// - mode bit selects postamble length, both parties follow it
// - mode bit selects latency set A or B, both parties use it
`timescale 1ns/1ns
module burst_write_strobe_path (
	input wire logic clk,
	input wire logic rst,
	input wire logic ck,
	input wire logic cs,
	input wire logic [5:0] ca,
	input wire logic dqs_t,
	input wire logic [15:0] dq,
	input wire logic wpst_ext,
	input wire logic wl_set_b,
	input wire logic [4:0] rd_idx,
	output wire logic burst_done,
	output wr_path_pkg::burst_s burst_info,
	output wire logic rec_busy,
	output wire logic [15:0] rd_data
);
	import wr_path_pkg::*;

	// link reset: asserts at once, releases on ck
	logic rst_l1_q;
	logic rst_link_q;
	always_ff @(posedge ck or posedge rst) begin
		if (rst) begin
			rst_l1_q <= 1'b1;
			rst_link_q <= 1'b1;
		end else begin
			rst_l1_q <= 1'b0;
			rst_link_q <= rst_l1_q;
		end
	end

	// mode bits cross into the link domain as levels
	logic [1:0] mode_s1_q;
	logic [1:0] mode_s2_q;
	always_ff @(posedge ck or posedge rst_link_q) begin
		if (rst_link_q) begin
			mode_s1_q <= 2'h0;
			mode_s2_q <= 2'h0;
		end else begin
			mode_s1_q <= {wl_set_b, wpst_ext};
			mode_s2_q <= mode_s1_q;
		end
	end

	// link sequencer state
	link_st_e st_q, st_d;
	logic [4:0] cnt_q, cnt_d;
	logic [4:0] beat_q, beat_d;
	burst_s cmd_q, cmd_d;
	burst_s done_info_q, done_info_d;
	logic ext_q, ext_d;
	logic wlb_q, wlb_d;
	logic tgl_q, tgl_d;
	logic mem_we;
	logic [4:0] last_beat;
	logic [15:0] beat_mem [0:31];

	assign last_beat = cmd_q.bl32 ? LAST_BL32 : LAST_BL16;

	// one command step on the bus; both write steps decode through here
	function automatic logic step_hit(input logic sel, input logic [5:0] bus,
		input logic [4:0] code);
		return sel && bus[4:0] == code;
	endfunction : step_hit

	// next state of the sequencer; commands during a burst are not merged
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		beat_d = beat_q;
		cmd_d = cmd_q;
		done_info_d = done_info_q;
		ext_d = ext_q;
		wlb_d = wlb_q;
		tgl_d = tgl_q;
		mem_we = 1'b0;
		unique case (st_q)
			ST_IDLE: begin
				if (step_hit(cs, ca, WR1_CODE)) begin
					cmd_d = '0;
					cmd_d.bl32 = ca[CA_BL_BIT];
					st_d = ST_W1B;
				end
			end
			ST_W1B: begin
				cmd_d.bank = ca[2:0];
				cmd_d.col[9] = ca[CA_C9_BIT];
				st_d = ST_C2A;
			end
			ST_C2A: begin
				if (step_hit(cs, ca, CAS2_CODE)) begin
					cmd_d.col[8] = ca[CA_C8_BIT];
					st_d = ST_C2B;
				end else begin
					st_d = ST_IDLE; // broken sequence, drop it
				end
			end
			ST_C2B: begin
				// low column bits forced to zero, a nonzero c3/c2 is flagged
				cmd_d.col[7:4] = ca[5:2];
				cmd_d.col[3:0] = 4'h0;
				cmd_d.align_err = |ca[1:0];
				// mode settings are frozen per write so a change mid burst is harmless
				wlb_d = mode_s2_q[1];
				ext_d = mode_s2_q[0];
				cnt_d = (mode_s2_q[1] ? WL_SET_B : WL_SET_A) - 5'h01;
				st_d = ST_LAT;
			end
			ST_LAT: begin
				// strobe is not looked at here, preamble or not
				if (cnt_q == 5'h01) begin
					beat_d = 5'h00;
					st_d = ST_BURST;
				end else begin
					cnt_d = cnt_q - 5'h01;
				end
			end
			ST_BURST: begin
				// a beat is taken on each period that shows a latching strobe
				if (dqs_t) begin
					mem_we = 1'b1;
					beat_d = beat_q + 5'h01;
					if (beat_q == last_beat) begin
						cnt_d = ext_q ? POST_EXT_CYC : POST_STD_CYC;
						st_d = ST_POST;
					end
				end
			end
			ST_POST: begin
				if (cnt_q == 5'h01) begin
					done_info_d = cmd_q;
					tgl_d = ~tgl_q;
					st_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 5'h01;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge ck or posedge rst_link_q) begin
		if (rst_link_q) begin
			st_q <= ST_IDLE;
			cnt_q <= 5'h00;
			beat_q <= 5'h00;
			cmd_q <= '0;
			done_info_q <= '0;
			ext_q <= 1'b0;
			wlb_q <= 1'b0;
			tgl_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			beat_q <= beat_d;
			cmd_q <= cmd_d;
			done_info_q <= done_info_d;
			ext_q <= ext_d;
			wlb_q <= wlb_d;
			tgl_q <= tgl_d;
		end
	end

	// beat storage, no reset needed for data
	always_ff @(posedge ck) begin
		if (mem_we) begin
			beat_mem[beat_q] <= dq;
		end
	end

	a_latency_set_a: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_C2B && !mode_s2_q[1]) |-> ##1 (st_q == ST_LAT)[*5] ##1 st_q == ST_BURST)
		else $error("burst window not opened after latency set A");
	a_latency_set_b: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_C2B && mode_s2_q[1]) |-> ##1 (st_q == ST_LAT)[*7] ##1 st_q == ST_BURST)
		else $error("burst window not opened after latency set B");
	a_col_aligned: assert property (@(posedge ck) disable iff (rst_link_q)
		st_q == ST_C2B |=> cmd_q.col[3:0] == 4'h0
			&& cmd_q.align_err == ($past(ca[1:0]) != 2'h0))
		else $error("burst column not aligned or misalign flag wrong");
	a_no_early_beat: assert property (@(posedge ck) disable iff (rst_link_q)
		st_q != ST_BURST |-> !mem_we)
		else $error("beat captured outside the burst window");
	a_bl16_end: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_BURST && dqs_t && !cmd_q.bl32 && beat_q == 5'h0F) |=> st_q == ST_POST)
		else $error("16 beat burst did not end at its last beat");
	a_bl32_hold: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_BURST && cmd_q.bl32 && beat_q == 5'h0F) |=> st_q == ST_BURST)
		else $error("32 beat burst ended early");
	a_post_std: assert property (@(posedge ck) disable iff (rst_link_q)
		($rose(st_q == ST_POST) && !ext_q) |=> st_q == ST_IDLE && tgl_q != $past(tgl_q))
		else $error("standard postamble not one period");
	a_post_ext: assert property (@(posedge ck) disable iff (rst_link_q)
		($rose(st_q == ST_POST) && ext_q) |=> st_q == ST_POST ##1 st_q == ST_IDLE)
		else $error("extended postamble not two periods");

	// decode, mode capture and strobe gaps, all on the link clock
	a_wr1_start: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_IDLE && step_hit(cs, ca, WR1_CODE))
		|=> st_q == ST_W1B && cmd_q.bl32 == $past(ca[CA_BL_BIT]))
		else $error("write command first step not taken");
	a_cas2_drop: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_C2A && !step_hit(cs, ca, CAS2_CODE)) |=> st_q == ST_IDLE)
		else $error("broken command sequence not dropped");
	a_mode_frozen: assert property (@(posedge ck) disable iff (rst_link_q)
		st_q == ST_C2B |=> ext_q == $past(mode_s2_q[0]) && wlb_q == $past(mode_s2_q[1]))
		else $error("mode settings not frozen at write completion");
	a_skip_idle: assert property (@(posedge ck) disable iff (rst_link_q)
		(st_q == ST_BURST && !dqs_t) |=> st_q == ST_BURST && $stable(beat_q))
		else $error("beat counted without a latching strobe");

	// burst-done toggle crosses into the core domain
	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic done_q, done_d;
	burst_s info_q, info_d;
	logic [3:0] rec_cnt_q, rec_cnt_d;
	logic busy_q, busy_d;
	logic [15:0] rd_q, rd_d;

	// done pulse, burst record and recovery countdown
	always_comb begin
		done_d = tgl_s2_q ^ tgl_s3_q;
		info_d = info_q;
		rec_cnt_d = rec_cnt_q;
		busy_d = busy_q;
		// array words are stable once done has been seen
		rd_d = beat_mem[rd_idx];
		if (tgl_s2_q ^ tgl_s3_q) begin
			info_d = done_info_q; // held steady by the link since the toggle
			rec_cnt_d = TWR_CYC;
			busy_d = 1'b1;
		end else if (rec_cnt_q != 4'h0) begin
			rec_cnt_d = rec_cnt_q - 4'h1;
			busy_d = rec_cnt_q != 4'h1;
		end
	end

	// core domain registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			done_q <= 1'b0;
			info_q <= '0;
			rec_cnt_q <= 4'h0;
			busy_q <= 1'b0;
			rd_q <= 16'h0000;
		end else begin
			tgl_s1_q <= tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			done_q <= done_d;
			info_q <= info_d;
			rec_cnt_q <= rec_cnt_d;
			busy_q <= busy_d;
			rd_q <= rd_d;
		end
	end

	a_done_pulse: assert property (@(posedge clk) disable iff (rst)
		done_q |-> busy_q ##1 !done_q)
		else $error("done not a single pulse with recovery busy");
	// recovery window opens with done and closes after its count
	a_rec_start: assert property (@(posedge clk) disable iff (rst)
		$rose(done_q) |-> rec_cnt_q == TWR_CYC && busy_q)
		else $error("write recovery not started with done");
	a_rec_end: assert property (@(posedge clk) disable iff (rst)
		(rec_cnt_q == 4'h1 && !(tgl_s2_q ^ tgl_s3_q)) |=> !busy_q)
		else $error("write recovery not ended after its count");

	assign burst_done = done_q;
	assign burst_info = info_q;
	assign rec_busy = busy_q;
	assign rd_data = rd_q;
endmodule : burst_write_strobe_path

/* File: host_model.sv */
/*
 * model of the memory controller: write commands, strobe and data on ck.
 * assumes ck runs free and the bench calls write_burst from one process.
 */
`timescale 1ns/1ns
module host_model
	import wr_path_pkg::*;
(
	input wire logic ck,
	output logic cs,
	output logic [5:0] ca,
	output logic dqs_t,
	output logic [15:0] dq
);
	// lines idle at start
	initial begin
		cs = 1'b0;
		ca = 6'h00;
		dqs_t = 1'b0;
		dq = 16'h0000;
	end

	// one ck period: change after the fall, held over the next rise
	task automatic step(input logic c, input logic [5:0] a, input logic s, input logic [15:0] d);
		@(negedge ck);
		cs = c;
		ca = a;
		dqs_t = s;
		dq = d;
	endtask : step

	// released data never keeps its last value, so idle edges invert it
	task automatic write_burst(input logic [2:0] bank, input logic [9:0] col, input logic bl32,
		input logic wlb, input logic pext, input int gap, input logic [15:0] seed, input logic brk);
		int wl;
		int n;
		wl = wlb ? int'(WL_SET_B) : int'(WL_SET_A);
		n = bl32 ? 32 : 16;
		step(1'b1, {bl32, WR1_CODE}, 1'b0, ~dq);
		step(1'b0, {1'b0, col[9], 1'b0, bank}, 1'b0, ~dq);
		step(1'b1, {col[8], brk ? 5'h00 : CAS2_CODE}, 1'b0, ~dq);
		step(1'b0, col[7:2], 1'b0, ~dq);
		// strobe free before preamble, low for the preamble itself
		for (int i = 1; i < wl; i++) begin
			step(1'b0, 6'h00, i < wl - PRE_CYC, ~dq);
		end
		for (int i = 0; i < n; i++) begin
			if (i == gap) begin
				step(1'b0, 6'h00, 1'b0, ~dq); // slow strobe: one idle edge
			end
			step(1'b0, 6'h00, 1'b1, seed + 16'(i));
		end
		// strobe keeps toggling through the postamble; none of it is a beat
		for (int i = 0; i < (pext ? 2 : 1); i++) begin
			step(1'b0, 6'h00, 1'b1, ~dq);
		end
		step(1'b0, 6'h00, 1'b0, ~dq);
	endtask : write_burst
endmodule : host_model

/* File: test_burst_write_strobe_path.sv */
/*
 * self-checking bench for the burst write path with the controller model.
 * assumes the package constants and a one-cycle done pulse on the core side.
 */
`timescale 1ns/1ns
module test_burst_write_strobe_path;
	import wr_path_pkg::*;
	typedef struct {
		logic [2:0] bank;
		logic [9:0] col;
		logic bl32;
		logic wlb;
		logic pext;
		int gap;
		logic [15:0] seed;
		logic exp_err;
	} row_s;
	logic clk;
	logic rst;
	logic ck;
	logic cs;
	logic [5:0] ca;
	logic dqs_t;
	logic [15:0] dq;
	logic wpst_ext;
	logic wl_set_b;
	logic [4:0] rd_idx;
	logic burst_done;
	burst_s burst_info;
	logic rec_busy;
	logic [15:0] rd_data;
	logic seen;
	int fails;
	int tests_run;
	row_s rows[4] = '{
		'{3'h3, 10'h3F0, 1'b0, 1'b0, 1'b0, -1, 16'h1000, 1'b0},
		'{3'h7, 10'h2A4, 1'b1, 1'b1, 1'b1, 5, 16'h2000, 1'b1},
		'{3'h0, 10'h008, 1'b0, 1'b1, 1'b0, -1, 16'h3000, 1'b1},
		'{3'h5, 10'h150, 1'b1, 1'b0, 1'b1, 31, 16'h4A00, 1'b0}};

	// core clock, and a link clock of unrelated phase
	always #50 clk = ~clk;
	initial begin
		ck = 1'b0;
		#7;
		forever #80 ck = ~ck;
	end

	burst_write_strobe_path dut_u (.clk(clk), .rst(rst), .ck(ck), .cs(cs), .ca(ca),
		.dqs_t(dqs_t), .dq(dq), .wpst_ext(wpst_ext), .wl_set_b(wl_set_b), .rd_idx(rd_idx),
		.burst_done(burst_done), .burst_info(burst_info), .rec_busy(rec_busy), .rd_data(rd_data));
	host_model host_u (.ck(ck), .cs(cs), .ca(ca), .dqs_t(dqs_t), .dq(dq));

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %b", $time, what, got);
		end
	endtask : cmp_bit

	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : cmp_word

	task automatic report_and_stop();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	// one burst, then its report on the core side and every beat read back
	task automatic run_row(input row_s r, input logic brk);
		int k;
		burst_s exp;
		@(negedge clk);
		wpst_ext = r.pext;
		wl_set_b = r.wlb;
		repeat (8) @(negedge clk);
		host_u.write_burst(r.bank, r.col, r.bl32, r.wlb, r.pext, r.gap, r.seed, brk);
		k = 0;
		seen = 1'b0;
		while (k < 40 && !(burst_done === 1'b1 && !brk)) begin
			@(negedge clk);
			seen = seen | (burst_done === 1'b1);
			k++;
		end
		if (brk) begin
			cmp_bit(seen, 1'b0, "aborted command");
			return;
		end
		exp = '{bank: r.bank, col: {r.col[9:4], 4'h0}, bl32: r.bl32, align_err: r.exp_err};
		cmp_bit(burst_done, 1'b1, "done");
		cmp_word(16'(burst_info), 16'(exp), "info");
		cmp_bit(rec_busy, 1'b1, "recovery");
		@(negedge clk);
		cmp_bit(burst_done, 1'b0, "done width");
		cmp_bit(rec_busy, TWR_CYC > 4'h1, "recovery end");
		for (int i = 0; i < (r.bl32 ? 32 : 16); i++) begin
			rd_idx = 5'(i);
			@(negedge clk);
			cmp_word(rd_data, r.seed + 16'(i), "beat");
		end
	endtask : run_row

	// watchdog well beyond the expected run
	initial begin
		#400000;
		fails++;
		report_and_stop();
	end

	// reset, table rows, abort then recovery, reset mid-run
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wpst_ext = 1'b0;
		wl_set_b = 1'b0;
		rd_idx = 5'h00;
		fails = 0;
		tests_run = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		foreach (rows[i]) begin
			run_row(rows[i], 1'b0);
		end
		run_row(rows[2], 1'b1);
		run_row(rows[0], 1'b0);
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		cmp_bit(burst_done, 1'b0, "done in reset");
		cmp_word(16'(burst_info), 16'h0000, "info in reset");
		cmp_word(rd_data, 16'h0000, "data in reset");
		cmp_bit(rec_busy, 1'b0, "recovery in reset");
		// release again and prove a full burst still lands
		repeat (5) @(negedge clk);
		rst = 1'b0;
		run_row(rows[1], 1'b0);
		report_and_stop();
	end
endmodule : test_burst_write_strobe_path
